//--- rtl/dual_timer_counter_modes.sv
`timescale 1ns/1ps
`include "dual_timer_regs.svh"

module dual_timer_counter_modes (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire dual_timer_pkg::sfr_byte_t sfr_wdata,
  input wire logic sfr_rd,
  output dual_timer_pkg::sfr_byte_t sfr_rdata,
  input wire logic timer0_vector_ack,
  input wire logic timer1_vector_ack,
  input wire logic p0_pin5_alt_en,
  input wire logic p0_pin6_alt_en,
  input wire logic timer0_count_pin,
  input wire logic timer1_count_pin,
  input wire logic external_interrupt_zero_input,
  input wire logic external_interrupt_one_input,
  output logic timer0_overflow_flag,
  output logic timer1_overflow_flag,
  output logic timer0_out,
  output logic timer1_out
);
  import dual_timer_pkg::*;

  sfr_byte_t timer_mode_select_reg;
  sfr_byte_t timer_run_and_flags_reg;
  sfr_byte_t timer_clock_rate_reg;
  sfr_byte_t timer0_low_byte_reg;
  sfr_byte_t timer0_high_byte_reg;
  sfr_byte_t timer1_low_byte_reg;
  sfr_byte_t timer1_high_byte_reg;
  sfr_byte_t rdata_next;

  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [1:0] pin_prev_reg;
  logic [3:0] presc_reg;
  logic [1:0] pin_level;
  logic [1:0] pin_fall;
  logic tick_fast;
  logic tick_slow;
  logic int0_level;
  logic int1_level;

  timer_mode_e timer0_mode;
  timer_mode_e timer1_mode;
  logic timer0_rate_select;
  logic timer1_rate_select;
  logic timer0_run_bit;
  logic timer1_run_bit;
  logic timer0_div_tick;
  logic timer1_div_tick;
  logic timer0_tick;
  logic timer1_tick;
  logic timer0_inc;
  logic timer1_inc;
  logic timer0_high_inc;
  logic [16:0] timer0_step;
  logic [16:0] timer1_step;
  logic timer0_ovf;
  logic timer1_ovf;
  logic timer0_high_ovf;
  logic timer0_flag_set;
  logic timer1_flag_set;
  logic wr_run_flags;

  // one increment step; bit 16 is the overflow, 15:8 high byte, 7:0 low byte
  function automatic logic [16:0] count_step(
    input timer_mode_e mode,
    input logic [7:0] lo,
    input logic [7:0] hi
  );
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    logic [16:0] res;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8 = {1'b0, lo} + 9'h001;
    res = s16;
    unique case (mode)
      // upper three low-byte bits are left alone in 13-bit mode
      MODE_13BIT: res = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
      MODE_16BIT: res = s16;
      MODE_RELOAD8: res = {s8[8], hi, s8[8] ? hi : s8[7:0]};
      MODE_SPLIT8: res = {s8[8], hi, s8[7:0]};
    endcase
    return res;
  endfunction

  // pins and gates come from outside: two flops before any use
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
    end
    else
    begin
      sync1_reg <= {external_interrupt_one_input, external_interrupt_zero_input,
                    timer1_count_pin, timer0_count_pin};
      sync2_reg <= sync1_reg;
    end
  end

  // a pin outside its alternate function reads as idle high, so it never counts
  assign pin_level[0] = sync2_reg[0] | ~p0_pin5_alt_en;
  assign pin_level[1] = sync2_reg[1] | ~p0_pin6_alt_en;
  assign int0_level = sync2_reg[2];
  assign int1_level = sync2_reg[3];

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_prev_reg <= 2'h3;
    end
    else
    begin
      pin_prev_reg <= pin_level;
    end
  end

  assign pin_fall = pin_prev_reg & ~pin_level;

  // shared prescaler: one pass of twelve cycles, fast ticks every fourth
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      presc_reg <= 4'h0;
    end
    else if (presc_reg == `PRESCALE_LAST)
    begin
      presc_reg <= 4'h0;
    end
    else
    begin
      presc_reg <= presc_reg + 4'h1;
    end
  end

  assign tick_slow = (presc_reg == 4'h0);
  assign tick_fast = (presc_reg[1:0] == 2'h0);

  assign timer0_mode = timer_mode_e'(timer_mode_select_reg[`MS_T0_MODE_HI:`MS_T0_MODE_LO]);
  assign timer1_mode = timer_mode_e'(timer_mode_select_reg[`MS_T1_MODE_HI:`MS_T1_MODE_LO]);
  assign timer0_rate_select = timer_clock_rate_reg[`CR_T0_RATE];
  assign timer1_rate_select = timer_clock_rate_reg[`CR_T1_RATE];
  assign timer0_run_bit = timer_run_and_flags_reg[`RF_T0_RUN];
  assign timer1_run_bit = timer_run_and_flags_reg[`RF_T1_RUN];

  assign timer0_div_tick = timer0_rate_select ? tick_fast : tick_slow;
  assign timer1_div_tick = timer1_rate_select ? tick_fast : tick_slow;
  assign timer0_tick = timer_mode_select_reg[`MS_T0_SOURCE] ? pin_fall[0] : timer0_div_tick;
  assign timer1_tick = timer_mode_select_reg[`MS_T1_SOURCE] ? pin_fall[1] : timer1_div_tick;

  assign timer0_inc = timer0_tick & timer0_run_bit
                      & (~timer_mode_select_reg[`MS_T0_GATE] | int0_level);
  // split code on timer 1 stops it and holds its count
  assign timer1_inc = timer1_tick & timer1_run_bit
                      & (~timer_mode_select_reg[`MS_T1_GATE] | int1_level)
                      & (timer1_mode != MODE_SPLIT8);
  // high byte of timer 0 in split mode: divided clocks only, no gate
  assign timer0_high_inc = (timer0_mode == MODE_SPLIT8) & timer1_run_bit & timer0_div_tick;

  assign timer0_step = count_step(timer0_mode, timer0_low_byte_reg, timer0_high_byte_reg);
  assign timer1_step = count_step(timer1_mode, timer1_low_byte_reg, timer1_high_byte_reg);
  assign timer0_ovf = timer0_inc & timer0_step[16];
  assign timer1_ovf = timer1_inc & timer1_step[16];
  assign timer0_high_ovf = timer0_high_inc & (timer0_high_byte_reg == 8'hFF);

  // while timer 0 borrows the timer 1 flag, timer 1 overflows only pulse its output
  assign timer0_flag_set = timer0_ovf;
  assign timer1_flag_set = timer0_high_ovf | (timer1_ovf & (timer0_mode != MODE_SPLIT8));

  assign wr_run_flags = sfr_wr & (sfr_addr == `ADDR_RUN_FLAGS);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      timer_mode_select_reg <= `RST_MODE_SELECT;
    end
    else if (sfr_wr && sfr_addr == `ADDR_MODE_SELECT)
    begin
      timer_mode_select_reg <= sfr_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      timer_clock_rate_reg <= `RST_CLOCK_RATE;
    end
    else if (sfr_wr && sfr_addr == `ADDR_CLOCK_RATE)
    begin
      timer_clock_rate_reg <= sfr_wdata & 8'h18;
    end
  end

  // run bits are software-only; flags: hardware set beats write and vector clear
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      timer_run_and_flags_reg <= `RST_RUN_FLAGS;
    end
    else
    begin
      if (wr_run_flags)
      begin
        timer_run_and_flags_reg[`RF_T0_RUN] <= sfr_wdata[`RF_T0_RUN];
        timer_run_and_flags_reg[`RF_T1_RUN] <= sfr_wdata[`RF_T1_RUN];
      end
      if (timer0_flag_set)
      begin
        timer_run_and_flags_reg[`RF_T0_FLAG] <= 1'b1;
      end
      else if (wr_run_flags)
      begin
        timer_run_and_flags_reg[`RF_T0_FLAG] <= sfr_wdata[`RF_T0_FLAG];
      end
      else if (timer0_vector_ack)
      begin
        timer_run_and_flags_reg[`RF_T0_FLAG] <= 1'b0;
      end
      if (timer1_flag_set)
      begin
        timer_run_and_flags_reg[`RF_T1_FLAG] <= 1'b1;
      end
      else if (wr_run_flags)
      begin
        timer_run_and_flags_reg[`RF_T1_FLAG] <= sfr_wdata[`RF_T1_FLAG];
      end
      else if (timer1_vector_ack)
      begin
        timer_run_and_flags_reg[`RF_T1_FLAG] <= 1'b0;
      end
    end
  end

  // a software write to a count byte wins over a same-cycle increment
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      timer0_low_byte_reg <= `RST_COUNT_BYTE;
      timer0_high_byte_reg <= `RST_COUNT_BYTE;
    end
    else
    begin
      if (sfr_wr && sfr_addr == `ADDR_T0_LOW)
      begin
        timer0_low_byte_reg <= sfr_wdata;
      end
      else if (timer0_inc)
      begin
        timer0_low_byte_reg <= timer0_step[7:0];
      end
      if (sfr_wr && sfr_addr == `ADDR_T0_HIGH)
      begin
        timer0_high_byte_reg <= sfr_wdata;
      end
      else if (timer0_mode == MODE_SPLIT8)
      begin
        if (timer0_high_inc)
        begin
          timer0_high_byte_reg <= timer0_high_byte_reg + 8'h01;
        end
      end
      else if (timer0_inc)
      begin
        timer0_high_byte_reg <= timer0_step[15:8];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      timer1_low_byte_reg <= `RST_COUNT_BYTE;
      timer1_high_byte_reg <= `RST_COUNT_BYTE;
    end
    else
    begin
      if (sfr_wr && sfr_addr == `ADDR_T1_LOW)
      begin
        timer1_low_byte_reg <= sfr_wdata;
      end
      else if (timer1_inc)
      begin
        timer1_low_byte_reg <= timer1_step[7:0];
      end
      if (sfr_wr && sfr_addr == `ADDR_T1_HIGH)
      begin
        timer1_high_byte_reg <= sfr_wdata;
      end
      else if (timer1_inc)
      begin
        timer1_high_byte_reg <= timer1_step[15:8];
      end
    end
  end

  // output pulses last exactly one cycle after the overflowing increment
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      timer0_out <= 1'b0;
      timer1_out <= 1'b0;
    end
    else
    begin
      timer0_out <= timer0_ovf;
      timer1_out <= timer1_ovf;
    end
  end

  assign timer0_overflow_flag = timer_run_and_flags_reg[`RF_T0_FLAG];
  assign timer1_overflow_flag = timer_run_and_flags_reg[`RF_T1_FLAG];

  always_comb
  begin
    unique case (sfr_addr)
      `ADDR_RUN_FLAGS: rdata_next = timer_run_and_flags_reg;
      `ADDR_MODE_SELECT: rdata_next = timer_mode_select_reg;
      `ADDR_T0_LOW: rdata_next = timer0_low_byte_reg;
      `ADDR_T1_LOW: rdata_next = timer1_low_byte_reg;
      `ADDR_T0_HIGH: rdata_next = timer0_high_byte_reg;
      `ADDR_T1_HIGH: rdata_next = timer1_high_byte_reg;
      `ADDR_CLOCK_RATE: rdata_next = timer_clock_rate_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // read data is registered; it holds until the next read strobe
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sfr_rdata <= 8'h00;
    end
    else if (sfr_rd)
    begin
      sfr_rdata <= rdata_next;
    end
  end

endmodule

//--- rtl/dual_timer_pkg.sv
package dual_timer_pkg;

  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD8 = 2'b10,
    MODE_SPLIT8 = 2'b11
  } timer_mode_e;

  typedef logic [7:0] sfr_byte_t;

endpackage

//--- rtl/dual_timer_regs.svh
`ifndef DUAL_TIMER_REGS_SVH
`define DUAL_TIMER_REGS_SVH

// register addresses on the special-function bus
`define ADDR_RUN_FLAGS 8'h88
`define ADDR_MODE_SELECT 8'h89
`define ADDR_T0_LOW 8'h8A
`define ADDR_T1_LOW 8'h8B
`define ADDR_T0_HIGH 8'h8C
`define ADDR_T1_HIGH 8'h8D
`define ADDR_CLOCK_RATE 8'h8E

// timer_run_and_flags fields
`define RF_T1_FLAG 7
`define RF_T1_RUN 6
`define RF_T0_FLAG 5
`define RF_T0_RUN 4

// timer_mode_select fields
`define MS_T1_GATE 7
`define MS_T1_SOURCE 6
`define MS_T1_MODE_HI 5
`define MS_T1_MODE_LO 4
`define MS_T0_GATE 3
`define MS_T0_SOURCE 2
`define MS_T0_MODE_HI 1
`define MS_T0_MODE_LO 0

// timer_clock_rate_register fields
`define CR_T1_RATE 4
`define CR_T0_RATE 3

// reset values
`define RST_RUN_FLAGS 8'h00
`define RST_MODE_SELECT 8'h00
`define RST_CLOCK_RATE 8'h00
`define RST_COUNT_BYTE 8'h00

// prescaler: cpu clocks per increment, slow and fast rates
`define DIV_SLOW 12
`define DIV_FAST 4
`define PRESCALE_LAST 4'hB

`endif

//--- verification/dual_timer_monitor.sv
`timescale 1ns/1ps
module dual_timer_monitor (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire dual_timer_pkg::sfr_byte_t sfr_wdata,
  input wire logic sfr_rd,
  input wire dual_timer_pkg::sfr_byte_t sfr_rdata,
  input wire logic timer0_vector_ack,
  input wire logic timer1_vector_ack,
  input wire logic p0_pin5_alt_en,
  input wire logic p0_pin6_alt_en,
  input wire logic timer0_count_pin,
  input wire logic timer1_count_pin,
  input wire logic external_interrupt_zero_input,
  input wire logic external_interrupt_one_input,
  input wire logic timer0_overflow_flag,
  input wire logic timer1_overflow_flag,
  input wire logic timer0_out,
  input wire logic timer1_out
);
  import dual_timer_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_out0_pulse; timer0_out |=> !timer0_out; endproperty
  a_out0_pulse: assert property (p_out0_pulse) else $error("timer0_out too long");
  property p_out1_pulse; timer1_out |=> !timer1_out; endproperty
  a_out1_pulse: assert property (p_out1_pulse) else $error("timer1_out too long");
  // a flag may only drop through a vector ack or a register write
  property p_flag0_hold;
    $fell(timer0_overflow_flag) |-> $past(timer0_vector_ack) || ($past(sfr_wr) && $past(sfr_addr) == 8'h88);
  endproperty
  a_flag0_hold: assert property (p_flag0_hold) else $error("flag0 dropped");
  property p_flag1_hold;
    $fell(timer1_overflow_flag) |-> $past(timer1_vector_ack) || ($past(sfr_wr) && $past(sfr_addr) == 8'h88);
  endproperty
  a_flag1_hold: assert property (p_flag1_hold) else $error("flag1 dropped");
  // a new overflow in the ack cycle wins; its out pulse stands in the next cycle
  property p_ack0_clr;
    timer0_vector_ack && !(sfr_wr && sfr_addr == 8'h88) |=> !timer0_overflow_flag || timer0_out;
  endproperty
  a_ack0_clr: assert property (p_ack0_clr) else $error("ack0 kept flag");
  // flag and out pulse come from the same overflow edge, so both stand together here
  property p_out0_flag; $rose(timer0_out) |-> timer0_overflow_flag; endproperty
  a_out0_flag: assert property (p_out0_flag) else $error("out0 without flag");
  property p_rd_hold; !sfr_rd |=> $stable(sfr_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_mode_rb;
    sfr_wr && sfr_addr == 8'h89 ##1 !sfr_wr ##1 sfr_rd && sfr_addr == 8'h89 |=> sfr_rdata == $past(sfr_wdata, 3);
  endproperty
  a_mode_rb: assert property (p_mode_rb) else $error("mode readback");
  property p_rate_rb;
    sfr_wr && sfr_addr == 8'h8E ##1 !sfr_wr ##1 sfr_rd && sfr_addr == 8'h8E |=>
      sfr_rdata == ($past(sfr_wdata, 3) & 8'h18);
  endproperty
  a_rate_rb: assert property (p_rate_rb) else $error("rate readback");
  c_flag0: cover property ($rose(timer0_overflow_flag));
  c_flag1: cover property ($rose(timer1_overflow_flag));
  c_out1: cover property ($rose(timer1_out));
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dual_timer_pkg::*;
  logic clk_sys = 0, rstn = 0, sfr_wr = 0, sfr_rd = 0;
  logic [7:0] sfr_addr = 8'h00;
  sfr_byte_t sfr_wdata = 8'h00, sfr_rdata, v;
  logic ack0 = 0, ack1 = 0, alt6 = 0, pin1 = 1, ie0 = 1, alt5 = 1, pin0 = 1, ie1 = 1;
  logic f0, f1, o0, o1;
  int errors = 0, n_compared = 0, cyc = 0, n;
  dual_timer_counter_modes dut_u (.clk_sys, .rstn, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata,
    .timer0_vector_ack(ack0), .timer1_vector_ack(ack1), .p0_pin5_alt_en(alt5), .p0_pin6_alt_en(alt6),
    .timer0_count_pin(pin0), .timer1_count_pin(pin1), .external_interrupt_zero_input(ie0),
    .external_interrupt_one_input(ie1), .timer0_overflow_flag(f0), .timer1_overflow_flag(f1),
    .timer0_out(o0), .timer1_out(o1));
  initial forever #12.5 clk_sys = ~clk_sys;
  task final_report();
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      errors++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    idle(1);
    sfr_wr = 0;
    // one idle edge between strobes, so a strobe is never lowered and raised in one step
    idle(1);
  endtask
  // empty name reads without comparing
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    sfr_addr = a;
    sfr_rd = 1;
    idle(1);
    sfr_rd = 0;
    v = sfr_rdata;
    if (nm != "") chk(nm, e, v);
    idle(1);
  endtask
  task automatic wt(input int s, input int lim);
    n = 0;
    while ((s == 0 ? o0 : s == 1 ? o1 : f1) !== 1'b1 && n < lim)
    begin
      idle(1);
      n++;
    end
    if (n >= lim) chk("wait", 1, 0);
  endtask
  // pulse is long enough to get through the pin synchroniser
  task automatic pulse1();
    pin1 = 0;
    idle(4);
    pin1 = 1;
    idle(4);
  endtask
  task automatic pulse0();
    pin0 = 0;
    idle(4);
    pin0 = 1;
    idle(4);
  endtask
  initial
  begin
    idle(2);
    rstn = 1;
    for (int a = 8'h88; a <= 8'h8E; a++) rd(a[7:0], 8'h00, "reset");
    wr(8'h87, 8'hFF);
    rd(8'h87, 8'h00, "unmapped");
    wr(8'h89, 8'hA5);
    rd(8'h89, 8'hA5, "mode");
    wr(8'h8E, 8'hFF);
    rd(8'h8E, 8'h18, "rate");
    wr(8'h8A, 8'h12);
    wr(8'h8C, 8'h34);
    idle(30);
    rd(8'h8A, 8'h12, "t0_low_stopped");
    rd(8'h8C, 8'h34, "t0_high");
    wr(8'h89, 8'h01);
    wr(8'h8E, 8'h08);
    wr(8'h8A, 8'hFE);
    wr(8'h8C, 8'hFF);
    wr(8'h88, 8'h10);
    wt(0, 20);
    chk("fast", 1, n <= 10);
    chk("flag0", 1, f0);
    wr(8'h88, 8'h20);
    rd(8'h8A, 8'h00, "t0_low_wrap");
    rd(8'h8C, 8'h00, "t0_high_wrap");
    ack0 = 1;
    idle(1);
    ack0 = 0;
    chk("ack0", 0, f0);
    wr(8'h8E, 8'h00);
    wr(8'h89, 8'h00);
    wr(8'h8B, 8'hFE);
    wr(8'h8D, 8'hFF);
    wr(8'h88, 8'h40);
    wt(1, 40);
    chk("slow", 1, n >= 13);
    chk("flag1", 1, f1);
    wr(8'h88, 8'h80);
    rd(8'h88, 8'h80, "flags");
    rd(8'h8B, 8'hE0, "t1_low_13bit");
    ack1 = 1;
    idle(1);
    ack1 = 0;
    chk("ack1", 0, f1);
    ie0 = 0;
    wr(8'h8E, 8'h08);
    wr(8'h89, 8'h09);
    wr(8'h8A, 8'h00);
    wr(8'h88, 8'h10);
    idle(30);
    rd(8'h8A, 8'h00, "gated");
    ie0 = 1;
    idle(30);
    rd(8'h8A, 8'h00, "");
    chk("ungated", 1, v != 0);
    wr(8'h89, 8'h60);
    wr(8'h8D, 8'hF0);
    wr(8'h8B, 8'hFE);
    alt6 = 1;
    wr(8'h88, 8'h40);
    pulse1();
    rd(8'h8B, 8'hFF, "pin_count");
    pulse1();
    rd(8'h8B, 8'hF0, "reload");
    chk("flag1_pin", 1, f1);
    alt6 = 0;
    pulse1();
    rd(8'h8B, 8'hF0, "alt_off");
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h33);
    wr(8'h8B, 8'h55);
    wr(8'h8C, 8'hFF);
    wr(8'h88, 8'h40);
    wt(2, 12);
    chk("split_f0", 0, f0);
    rd(8'h8B, 8'h55, "t1_hold");
    wr(8'h88, 8'h00);
    ie1 = 0;
    wr(8'h89, 8'h95);
    wr(8'h8A, 8'h00);
    wr(8'h8B, 8'h00);
    wr(8'h88, 8'h50);
    pulse0();
    pulse0();
    rd(8'h8A, 8'h02, "t0_pin");
    alt5 = 0;
    pulse0();
    rd(8'h8A, 8'h02, "t0_alt_off");
    alt5 = 1;
    rd(8'h8B, 8'h00, "t1_gated");
    ie1 = 1;
    idle(30);
    rd(8'h8A, 8'h02, "t0_no_clock");
    rd(8'h8B, 8'h00, "");
    chk("t1_ungated", 1, v != 0);
    final_report();
  end
endmodule
bind dual_timer_counter_modes dual_timer_monitor mon_u (.clk_sys, .rstn, .sfr_addr, .sfr_wr, .sfr_wdata,
  .sfr_rd, .sfr_rdata, .timer0_vector_ack, .timer1_vector_ack, .p0_pin5_alt_en, .p0_pin6_alt_en,
  .timer0_count_pin, .timer1_count_pin, .external_interrupt_zero_input, .external_interrupt_one_input,
  .timer0_overflow_flag, .timer1_overflow_flag, .timer0_out, .timer1_out);
